//--- src/frame_filter_defines.vh
// register map, field positions and reset values of the receive frame filter
`ifndef FRAME_FILTER_DEFINES_VH
`define FRAME_FILTER_DEFINES_VH

`define FF_CTRL_ADDR 12'h708
`define FF_ENABLE_ADDR 12'h70C
`define FF_VALUE_FIRST 12'h710
`define FF_VALUE_LAST 12'h74C
`define FF_MASK_FIRST 12'h750
`define FF_MASK_LAST 12'h78C
`define FF_MASK_SPARE 12'h790

`define FF_PROMISC_BIT 31
`define FF_CLASS_SEL_BIT 8
`define FF_INDEX_MSB 3
`define FF_ENABLE_BIT 0

`define FF_CTRL_RESET 32'h80000000
`define FF_ENABLE_RESET 1'b1

`define FF_WORDS 16
`define FF_BYTES 7'h40
`define FF_CLASS_COUNT 3

`define FF_BCAST_LOW 32'hFFFFFFFF
`define FF_BCAST_HIGH 32'h0000FFFF
`define FF_SYNC_VAL0 32'h00C28001
`define FF_SYNC_VAL1 32'h00000E00
`define FF_SYNC_VAL3 32'h0000F788
`define FF_SYNC_MSK0 32'hFFFFFFFF
`define FF_SYNC_MSK1 32'h0000FFFF
`define FF_SYNC_MSK3 32'h0000FFFF
`define FF_CLASS_A_VAL3 32'h02600081
`define FF_CLASS_B_VAL3 32'h02400081
`define FF_CLASS_MSK3 32'hFFFFFFFF

`endif

//--- src/receive_frame_filter_table.v
// receive frame filter table with ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "frame_filter_defines.vh"

module receive_frame_filter_table #(
    parameter FILTER_PRESENT = 1,
    parameter NUM_FILTERS = 16,
    parameter CLASS_FILTERS = 1
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [7:0] rx_data,
    input wire rx_valid,
    input wire rx_last,
    output reg frame_done,
    output reg frame_accept,
    output reg [NUM_FILTERS+`FF_CLASS_COUNT-1:0] filter_hits
);

    localparam NCLS = CLASS_FILTERS ? `FF_CLASS_COUNT : 0;
    localparam TOT = NUM_FILTERS + NCLS;
    localparam HW = NUM_FILTERS + `FF_CLASS_COUNT;

    // ------------------------------------------------------------
    // reset contents of the table
    // ------------------------------------------------------------
    // general filters default to the broadcast address
    function [31:0] init_word;
        input integer f;
        input integer w;
        input is_mask;
        begin
            init_word = 32'h00000000;
            if (f < NUM_FILTERS) begin
                if (w == 0)
                    init_word = `FF_BCAST_LOW;
                else if (w == 1)
                    init_word = `FF_BCAST_HIGH;
            end else if (f == NUM_FILTERS) begin
                if (w == 0)
                    init_word = is_mask ? `FF_SYNC_MSK0 : `FF_SYNC_VAL0;
                else if (w == 1)
                    init_word = is_mask ? `FF_SYNC_MSK1 : `FF_SYNC_VAL1;
                else if (w == 3)
                    init_word = is_mask ? `FF_SYNC_MSK3 : `FF_SYNC_VAL3;
            end else if (w == 3) begin
                if (is_mask)
                    init_word = `FF_CLASS_MSK3;
                else if (f == NUM_FILTERS + 1)
                    init_word = `FF_CLASS_A_VAL3;
                else
                    init_word = `FF_CLASS_B_VAL3;
            end
        end
    endfunction

    reg [31:0] val_mem [0:TOT*`FF_WORDS-1];
    reg [31:0] msk_mem [0:TOT*`FF_WORDS-1];
    reg [TOT-1:0] enable;
    reg promisc;
    reg class_filter_select;
    reg [3:0] filter_index;

    // ------------------------------------------------------------
    // filter selection
    // ------------------------------------------------------------
    wire sel_ok;
    wire [4:0] sel;
    assign sel_ok = class_filter_select ?
        (NCLS != 0 && filter_index < 4'h3) :
        ({1'b0, filter_index} < NUM_FILTERS[4:0]);
    // class filters sit after the general ones in the table
    assign sel = class_filter_select ?
        (NUM_FILTERS[4:0] + {1'b0, filter_index}) :
        {1'b0, filter_index};

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    reg ph_write;
    reg ph_read;
    reg rd_wait;
    reg [11:0] ph_addr;
    wire take;
    wire [3:0] ph_word;
    wire ph_val;
    wire ph_msk;
    wire is_ctrl;
    wire is_enable;
    wire rd_stall;
    assign take = hsel & htrans[1] & hready;
    // word offset inside the 16-word value or mask window
    assign ph_word = ph_addr[5:2] - 4'h4;
    assign ph_val = ph_addr >= `FF_VALUE_FIRST && ph_addr <= `FF_VALUE_LAST;
    assign ph_msk = ph_addr >= `FF_MASK_FIRST && ph_addr <= `FF_MASK_LAST;
    assign is_ctrl = ph_addr == `FF_CTRL_ADDR;
    assign is_enable = ph_addr == `FF_ENABLE_ADDR;
    // reads take one wait state so a write just before is seen
    assign rd_stall = ph_read & ~rd_wait;
    assign hreadyout = ~rd_stall;
    // the bus never errors; unmapped addresses read as zero
    assign hresp = 1'b0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_write <= 1'b0;
            ph_read <= 1'b0;
            rd_wait <= 1'b0;
            ph_addr <= 12'h000;
        end else begin
            rd_wait <= rd_stall;
            // a new address phase is only taken while the bus is ready
            if (hreadyout) begin
                ph_write <= take & hwrite;
                ph_read <= take & ~hwrite;
                if (take)
                    ph_addr <= haddr[11:0];
            end
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    integer i;
    integer k;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            promisc <= |(`FF_CTRL_RESET >> `FF_PROMISC_BIT);
            class_filter_select <= 1'b0;
            filter_index <= 4'h0;
            enable <= {TOT{`FF_ENABLE_RESET}};
            for (i = 0; i < TOT; i = i + 1) begin
                for (k = 0; k < `FF_WORDS; k = k + 1) begin
                    val_mem[i*`FF_WORDS+k] <= init_word(i, k, 1'b0);
                    msk_mem[i*`FF_WORDS+k] <= init_word(i, k, 1'b1);
                end
            end
        end else if (ph_write && FILTER_PRESENT != 0) begin
            if (is_ctrl) begin
                promisc <= hwdata[`FF_PROMISC_BIT];
                class_filter_select <= hwdata[`FF_CLASS_SEL_BIT];
                filter_index <= hwdata[`FF_INDEX_MSB:0];
            end else if (sel_ok) begin
                if (is_enable)
                    enable[sel] <= hwdata[`FF_ENABLE_BIT];
                else if (ph_val)
                    val_mem[sel*`FF_WORDS+ph_word] <= hwdata;
                else if (ph_msk)
                    msk_mem[sel*`FF_WORDS+ph_word] <= hwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h00000000;
        if (is_ctrl) begin
            next_rdata[`FF_PROMISC_BIT] = promisc;
            next_rdata[`FF_CLASS_SEL_BIT] = class_filter_select;
            next_rdata[`FF_INDEX_MSB:0] = filter_index;
        end else if (sel_ok) begin
            if (is_enable)
                next_rdata[`FF_ENABLE_BIT] = enable[sel];
            else if (ph_val)
                next_rdata = val_mem[sel*`FF_WORDS+ph_word];
            else if (ph_msk)
                next_rdata = msk_mem[sel*`FF_WORDS+ph_word];
        end
        if (FILTER_PRESENT == 0)
            next_rdata = 32'h00000000;
    end

    always @(posedge hclk or negedge hresetn) begin
        // read data holds until the next read is answered
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (rd_stall)
            hrdata <= next_rdata;
    end

    // ------------------------------------------------------------
    // frame comparison
    // ------------------------------------------------------------
    // byte position in the frame, saturates past the compared window
    reg [6:0] pos;
    // sticky per-filter mismatch over the current frame
    reg [TOT-1:0] miss;
    wire [TOT-1:0] miss_now;
    wire [TOT-1:0] miss_all;
    wire [TOT-1:0] hit;
    wire in_window;
    wire frame_end;
    assign in_window = pos < `FF_BYTES;
    assign frame_end = rx_valid & rx_last;

    genvar g;
    generate
        for (g = 0; g < TOT; g = g + 1) begin : cmp
            wire [31:0] vw;
            wire [31:0] mw;
            wire [7:0] vb;
            wire [7:0] mb;
            assign vw = val_mem[g*`FF_WORDS+pos[5:2]] >> {pos[1:0], 3'b000};
            assign mw = msk_mem[g*`FF_WORDS+pos[5:2]] >> {pos[1:0], 3'b000};
            assign vb = vw[7:0];
            assign mb = mw[7:0];
            assign miss_now[g] = in_window && (|((rx_data ^ vb) & mb));
            assign miss_all[g] = miss[g] | miss_now[g];
            assign hit[g] = ~enable[g] | ~miss_all[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // per-filter hits widened to the port
    // ------------------------------------------------------------
    // class bits stay zero when the class option is left out
    wire [HW-1:0] hit_pad;
    genvar p;
    generate
        for (p = 0; p < HW; p = p + 1) begin : pad
            if (p < TOT) begin : used
                assign hit_pad[p] = hit[p];
            end else begin : unused
                assign hit_pad[p] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // frame verdict
    // ------------------------------------------------------------
    reg next_accept;
    reg [HW-1:0] next_hits;
    always @* begin
        next_accept = 1'b1;
        next_hits = {HW{1'b0}};
        if (FILTER_PRESENT != 0) begin
            next_accept = promisc | (|hit);
            next_hits = hit_pad;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos <= 7'h00;
            miss <= {TOT{1'b0}};
            frame_done <= 1'b0;
            frame_accept <= 1'b0;
            filter_hits <= {HW{1'b0}};
        end else begin
            frame_done <= frame_end;
            if (rx_valid) begin
                if (rx_last) begin
                    // the next frame starts at byte zero with no misses
                    pos <= 7'h00;
                    miss <= {TOT{1'b0}};
                    frame_accept <= next_accept;
                    filter_hits <= next_hits;
                end else begin
                    miss <= miss_all;
                    if (in_window)
                        pos <= pos + 7'h01;
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- sim/receive_frame_filter_table_checker.sv
// concurrent checks on the frame filter bus and frame ports
`timescale 1ns/1ns
`default_nettype none
module receive_frame_filter_table_checker #(parameter NUM_FILTERS = 16) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire rx_valid,
    input wire rx_last,
    input wire frame_done,
    input wire frame_accept,
    input wire [NUM_FILTERS+2:0] filter_hits
);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire req = hsel && htrans[1] && hready;
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    AST_RD_WAIT: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WR_NOWAIT: assert property (req && hwrite |=> hreadyout)
        else $error("write stalled");
    AST_DONE: assert property (rx_valid && rx_last |=> frame_done)
        else $error("frame end not flagged");
    AST_DONE_CAUSE: assert property (frame_done |-> $past(rx_valid && rx_last))
        else $error("frame end without last byte");
    AST_HOLD: assert property (!frame_done |-> $stable(frame_accept))
        else $error("verdict changed between frames");
    AST_HITS_HOLD: assert property (!frame_done |-> $stable(filter_hits))
        else $error("hits changed between frames");
    AST_ACCEPT: assert property (frame_done && filter_hits != 0 |-> frame_accept)
        else $error("passing filter but frame refused");
endmodule
bind receive_frame_filter_table receive_frame_filter_table_checker
    #(.NUM_FILTERS(NUM_FILTERS)) chk (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .rx_valid, .rx_last, .frame_done,
    .frame_accept, .filter_hits);
`default_nettype wire

//--- sim/receive_frame_filter_table_bench.sv
// self-checking bench of the receive frame filter table
`timescale 1ns/1ns
`default_nettype none
module receive_frame_filter_table_bench;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rx_valid = 0;
    logic rx_last = 0, promisc = 1;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [7:0] rx_data = 0;
    logic [7:0] fb [0:71];
    logic [31:0] ev [0:18][0:15], em [0:18][0:15];
    logic [18:0] en = '1, hits;
    wire [31:0] hrdata;
    wire hreadyout, hresp, frame_done, frame_accept;
    wire [18:0] filter_hits;
    int fails = 0, num_checks = 0;
    always #5 hclk = ~hclk;
    receive_frame_filter_table receive_frame_filter_table_inst (.hclk,
        .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_data,
        .rx_valid, .rx_last, .frame_done, .frame_accept, .filter_hits);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rv(int f, int w, bit m);
        if (f < 16)
            return w == 0 ? 32'hFFFFFFFF : w == 1 ? 32'h0000FFFF : 32'h0;
        if (f == 16) case (w)
            0: return m ? 32'hFFFFFFFF : 32'h00C28001;
            1: return m ? 32'h0000FFFF : 32'h00000E00;
            3: return m ? 32'h0000FFFF : 32'h0000F788;
            default: return 32'h0;
        endcase
        if (w != 3) return 32'h0;
        return m ? 32'hFFFFFFFF : f == 17 ? 32'h02600081 : 32'h02400081;
    endfunction
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rdy();
        logic r;
        do begin
            @(negedge hclk);
            r = hreadyout;
            q = hrdata;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask
    task automatic bus(bit w, int a, logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 32'(a)};
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
    endtask
    task automatic sel(int f);
        bus(1, 'h708, 32'(f % 16 + (f > 15) * 256));
    endtask
    task automatic frame(int n);
        logic ok;
        for (int f = 0; f < 19; f++) begin
            ok = 1;
            for (int i = 0; i < n && i < 64; i++)
                if ((fb[i] ^ ev[f][i/4][8*(i%4)+:8]) & em[f][i/4][8*(i%4)+:8])
                    ok = 0;
            hits[f] = ok | !en[f];
        end
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            {rx_valid, rx_last, rx_data} <= {1'b1, i == n - 1, fb[i]};
        end
        @(posedge hclk);
        {rx_valid, rx_last} <= 2'b0;
        @(negedge hclk);
        chk("done", 1, frame_done);
        chk("hits", hits, filter_hits);
        chk("accept", promisc | (|hits), frame_accept);
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #300000;
        fails++;
        conclude();
    end
    initial begin
        void'($urandom(50));
        foreach (ev[f, w]) {ev[f][w], em[f][w]} = {rv(f, w, 0), rv(f, w, 1)};
        foreach (fb[i]) fb[i] = $urandom;
        repeat (5) @(posedge hclk);
        hresetn <= 1;
        bus(0, 'h708, 0);
        chk("ctrl", 32'h80000000, q);
        frame(40);
        promisc = 0;
        for (int f = 0; f < 19; f++) begin
            sel(f);
            bus(0, 'h70C, 0);
            chk("enable", 1, q);
            for (int w = 0; w < 32; w++) begin
                bus(0, 'h710 + 4 * w, 0);
                chk("table", w < 16 ? ev[f][w] : em[f][w-16], q);
            end
        end
        bus(0, 'h790, 0);
        chk("spare", 0, q);
        bus(1, 'h708, 32'h103);
        bus(1, 'h710, 32'h12345678);
        bus(0, 'h710, 0);
        chk("bad index", 0, q);
        for (int k = 0; k < 60; k++) begin
            int f, w, g;
            f = $urandom_range(0, 18);
            w = $urandom_range(0, 15);
            g = $urandom_range(0, 18);
            ev[f][w] = $urandom;
            em[f][w] = $urandom & $urandom;
            en[f] = $urandom_range(0, 3) != 0;
            sel(f);
            bus(1, 'h710 + 4 * w, ev[f][w]);
            bus(1, 'h750 + 4 * w, em[f][w]);
            bus(1, 'h70C, 32'(en[f]));
            bus(0, 'h710 + 4 * w, 0);
            chk("readback", ev[f][w], q);
            foreach (fb[i]) fb[i] = i < 64 && $urandom_range(0, 7) ?
                ev[g][i/4][8*(i%4)+:8] : 8'($urandom);
            frame($urandom_range(1, 72));
        end
        conclude();
    end
endmodule
`default_nettype wire
